// >>> exec_consts.vh
// Constants shared by the call, loop and trap execution logic
`ifndef EXEC_CONSTS_VH
`define EXEC_CONSTS_VH

// Opcode patterns
`define OP_CALL_HI      7'h04
`define OP_LOOP_HI      7'h3f
`define OP_RETURN_HI    13'h0010
`define OP_INT_RETURN   16'h0002
`define OP_TRACE_RETURN 16'h0006

// Instruction field positions
`define F_HI_MSB        15
`define F_HI_LSB        9
`define F_LINK_MSB      8
`define F_LINK_LSB      6
`define F_MODE_MSB      5
`define F_MODE_LSB      3
`define F_REG_MSB       2
`define F_REG_LSB       0
`define F_OFF_MSB       5
`define F_OFF_LSB       0

// Destination modes
`define MODE_REG        3'h0
`define MODE_DEF        3'h1
`define MODE_AINC       3'h2
`define MODE_AINC_DEF   3'h3
`define MODE_ADEC       3'h4
`define MODE_ADEC_DEF   3'h5
`define MODE_INDEX      3'h6

// Register numbers
`define REG_SP          3'h6
`define REG_PC          3'h7

// Fixed trap vector addresses
`define VEC_ILLEGAL     16'h0008
`define VEC_BREAKPOINT  16'h000c
`define VEC_EMULATOR    16'h0018
`define VEC_TRAP        16'h001c

// Arithmetic and reset values
`define WORD_STEP       16'h0002
`define GPR_RESET       16'h0000
`define PSW_RESET       16'h0000

`endif

// >>> trap_vector_rom.v
// Fixed trap vector address table
`include "exec_consts.vh"

module trap_vector_rom (
  // Selection
  input  wire [1:0]  sel_in,
  // Vector address
  output reg  [15:0] vec_out
);

  // Vectors are constants; software has no way to move them
  always @* begin
    case (sel_in)
      2'h0:    vec_out = `VEC_ILLEGAL;
      2'h1:    vec_out = `VEC_BREAKPOINT;
      2'h2:    vec_out = `VEC_EMULATOR;
      2'h3:    vec_out = `VEC_TRAP;
      default: vec_out = `VEC_ILLEGAL;
    endcase
  end

endmodule

// >>> loop_branch_calc.v
// Decrement and backward branch arithmetic of the loop instruction
module loop_branch_calc (
  // Operands
  input  wire [15:0] count_in,
  input  wire [15:0] pc_in,
  input  wire [5:0]  offset_in,
  // Results
  output wire [15:0] count_out,
  output wire [15:0] pc_out
);

  wire [15:0] dec_count;
  wire [15:0] byte_offset;

  // Count drops by one; condition codes are never touched here
  assign dec_count   = count_in - 16'h0001;
  // Offset zero-extended, so the jump can only go backward
  assign byte_offset = {9'h000, offset_in, 1'b0};
  assign count_out   = dec_count;
  // Taken while nonzero, else fall through to the next word
  assign pc_out = (dec_count != 16'h0000) ? (pc_in - byte_offset)
                                          : pc_in;

endmodule

// >>> subroutine_loop_trap_exec.v
// Execution unit for call, return, loop and trap entry and exit
`include "exec_consts.vh"

module subroutine_loop_trap_exec (
  // Clock and reset
  input  wire        MCLK_IN,
  input  wire        RESETN_IN,
  // Instruction and trap issue
  input  wire        START_IN,
  input  wire [15:0] INSTR_IN,
  input  wire        TRAP_REQ_IN,
  input  wire [1:0]  TRAP_SEL_IN,
  // Register and status loads while idle; register read at any time
  input  wire        REG_WE_IN,
  input  wire [2:0]  REG_WSEL_IN,
  input  wire [15:0] REG_WDATA_IN,
  input  wire [2:0]  REG_RSEL_IN,
  input  wire        PSW_WE_IN,
  input  wire [15:0] PSW_WDATA_IN,
  // Memory answer
  input  wire        MEM_ACK_IN,
  input  wire [15:0] MEM_RDATA_IN,
  // Memory request
  output wire        MEM_REQ_OUT,
  output wire        MEM_WE_OUT,
  output wire [15:0] MEM_ADDR_OUT,
  output wire [15:0] MEM_WDATA_OUT,
  // Status
  output wire        BUSY_OUT,
  output wire        DONE_OUT,
  output wire        ILLEGAL_OUT,
  output wire [15:0] REG_RDATA_OUT,
  output wire [15:0] PSW_OUT
);

  // One-hot states
  localparam [11:0] S_IDLE   = 12'h001;
  localparam [11:0] S_EA     = 12'h002;
  localparam [11:0] S_IDX    = 12'h004;
  localparam [11:0] S_IND    = 12'h008;
  localparam [11:0] S_PUSHL  = 12'h010;
  localparam [11:0] S_POPR   = 12'h020;
  localparam [11:0] S_PUSHPS = 12'h040;
  localparam [11:0] S_PUSHPC = 12'h080;
  localparam [11:0] S_VECPC  = 12'h100;
  localparam [11:0] S_VECPS  = 12'h200;
  localparam [11:0] S_POPPC  = 12'h400;
  localparam [11:0] S_POPPS  = 12'h800;

  reg  [11:0] state_reg;
  reg  [15:0] gpr_reg [0:7];
  reg  [15:0] psw_reg;
  reg  [15:0] instr_reg;
  reg  [15:0] tmp_reg;
  reg  [15:0] ind_addr_reg;
  reg  [15:0] vec_reg;
  reg         mem_req_reg;
  reg         mem_we_reg;
  reg  [15:0] mem_addr_reg;
  reg  [15:0] mem_wdata_reg;
  reg         busy_reg;
  reg         done_reg;
  reg         illegal_reg;
  reg  [15:0] rdata_reg;
  integer     i;

  wire [2:0]  link_sel;
  wire [2:0]  dst_mode;
  wire [2:0]  dst_sel;
  wire [15:0] loop_count;
  wire [15:0] loop_pc;
  wire [15:0] rom_vec;
  wire [15:0] idx_base;
  wire [15:0] idx_addr;
  wire        mem_done;

  // Word step of the stack and autoincrement paths
  function [15:0] word_step;
    input [15:0] value;
    input        down;
    begin
      word_step = down ? (value - `WORD_STEP) : (value + `WORD_STEP);
    end
  endfunction

  // Opcode class of a word
  function is_call;
    input [15:0] w;
    begin
      is_call = (w[`F_HI_MSB:`F_HI_LSB] == `OP_CALL_HI);
    end
  endfunction

  function is_loop;
    input [15:0] w;
    begin
      is_loop = (w[`F_HI_MSB:`F_HI_LSB] == `OP_LOOP_HI);
    end
  endfunction

  function is_return;
    input [15:0] w;
    begin
      is_return = (w[15:3] == `OP_RETURN_HI);
    end
  endfunction

  // Memory access launch
  task mem_issue;
    input        we;
    input [15:0] addr;
    input [15:0] data;
    begin
      mem_req_reg   <= 1'b1;
      mem_we_reg    <= we;
      mem_addr_reg  <= addr;
      mem_wdata_reg <= data;
    end
  endtask

  // Back to idle with a completion pulse
  task finish;
    begin
      state_reg <= S_IDLE;
      busy_reg  <= 1'b0;
      done_reg  <= 1'b1;
    end
  endtask

  // Instruction fields
  assign link_sel = instr_reg[`F_LINK_MSB:`F_LINK_LSB];
  assign dst_mode = instr_reg[`F_MODE_MSB:`F_MODE_LSB];
  assign dst_sel  = instr_reg[`F_REG_MSB:`F_REG_LSB];

  // Index base: PC already stepped past the index word
  assign idx_base = (dst_sel == `REG_PC) ? word_step(gpr_reg[7], 1'b0)
                                         : gpr_reg[dst_sel];
  assign idx_addr = idx_base + MEM_RDATA_IN;
  // Request is held until memory acknowledges it
  assign mem_done = mem_req_reg & MEM_ACK_IN;

  loop_branch_calc u_loop (
    .count_in  (gpr_reg[link_sel]),
    .pc_in     (gpr_reg[7]),
    .offset_in (instr_reg[`F_OFF_MSB:`F_OFF_LSB]),
    .count_out (loop_count),
    .pc_out    (loop_pc)
  );

  trap_vector_rom u_vec (
    .sel_in  (TRAP_SEL_IN),
    .vec_out (rom_vec)
  );

  // Sequencer, register file and memory request, all one process
  always @(posedge MCLK_IN) begin
    if (!RESETN_IN) begin
      state_reg     <= S_IDLE;
      for (i = 0; i < 8; i = i + 1) begin
        gpr_reg[i] <= `GPR_RESET;
      end
      psw_reg       <= `PSW_RESET;
      instr_reg     <= 16'h0000;
      tmp_reg       <= 16'h0000;
      ind_addr_reg  <= 16'h0000;
      vec_reg       <= 16'h0000;
      mem_req_reg   <= 1'b0;
      mem_we_reg    <= 1'b0;
      mem_addr_reg  <= 16'h0000;
      mem_wdata_reg <= 16'h0000;
      busy_reg      <= 1'b0;
      done_reg      <= 1'b0;
      illegal_reg   <= 1'b0;
      rdata_reg     <= 16'h0000;
    end else begin
      done_reg    <= 1'b0;
      illegal_reg <= 1'b0;
      rdata_reg   <= gpr_reg[REG_RSEL_IN];
      if (mem_done) begin
        mem_req_reg <= 1'b0;
      end
      case (state_reg)
        S_IDLE: begin
          // A trap request outranks a new instruction
          if (TRAP_REQ_IN) begin
            vec_reg   <= rom_vec;
            busy_reg  <= 1'b1;
            state_reg <= S_PUSHPS;
          end else if (START_IN) begin
            instr_reg <= INSTR_IN;
            busy_reg  <= 1'b1;
            state_reg <= S_EA;
          end else begin
            // Host loads only while idle, so no race with the sequencer
            if (REG_WE_IN) begin
              gpr_reg[REG_WSEL_IN] <= REG_WDATA_IN;
            end
            if (PSW_WE_IN) begin
              psw_reg <= PSW_WDATA_IN;
            end
          end
        end
        S_EA: begin
          if (is_call(instr_reg)) begin
            // Target goes to temp first; stack and link wait
            case (dst_mode)
              `MODE_REG: begin
                illegal_reg <= 1'b1;
                vec_reg     <= `VEC_ILLEGAL;
                state_reg   <= S_PUSHPS;
              end
              `MODE_DEF: begin
                tmp_reg   <= gpr_reg[dst_sel];
                state_reg <= S_PUSHL;
              end
              `MODE_AINC: begin
                tmp_reg          <= gpr_reg[dst_sel];
                gpr_reg[dst_sel] <= word_step(gpr_reg[dst_sel], 1'b0);
                state_reg        <= S_PUSHL;
              end
              `MODE_AINC_DEF: begin
                // With SP this is the coroutine swap path
                ind_addr_reg     <= gpr_reg[dst_sel];
                gpr_reg[dst_sel] <= word_step(gpr_reg[dst_sel], 1'b0);
                state_reg        <= S_IND;
              end
              `MODE_ADEC: begin
                tmp_reg          <= word_step(gpr_reg[dst_sel], 1'b1);
                gpr_reg[dst_sel] <= word_step(gpr_reg[dst_sel], 1'b1);
                state_reg        <= S_PUSHL;
              end
              `MODE_ADEC_DEF: begin
                ind_addr_reg     <= word_step(gpr_reg[dst_sel], 1'b1);
                gpr_reg[dst_sel] <= word_step(gpr_reg[dst_sel], 1'b1);
                state_reg        <= S_IND;
              end
              default: begin
                state_reg <= S_IDX;
              end
            endcase
          end else if (is_return(instr_reg)) begin
            gpr_reg[7] <= gpr_reg[dst_sel];
            state_reg  <= S_POPR;
          end else if (is_loop(instr_reg)) begin
            // Status word is left alone on both outcomes
            gpr_reg[link_sel] <= loop_count;
            gpr_reg[7]        <= loop_pc;
            finish;
          end else if ((instr_reg == `OP_INT_RETURN) ||
                       (instr_reg == `OP_TRACE_RETURN)) begin
            state_reg <= S_POPPC;
          end else begin
            // Opcodes outside this unit complete with no effect
            finish;
          end
        end
        S_IDX: begin
          if (!mem_req_reg) begin
            mem_issue(1'b0, gpr_reg[7], 16'h0000);
          end else if (MEM_ACK_IN) begin
            gpr_reg[7] <= word_step(gpr_reg[7], 1'b0);
            if (dst_mode == `MODE_INDEX) begin
              tmp_reg   <= idx_addr;
              state_reg <= S_PUSHL;
            end else begin
              ind_addr_reg <= idx_addr;
              state_reg    <= S_IND;
            end
          end
        end
        S_IND: begin
          if (!mem_req_reg) begin
            mem_issue(1'b0, ind_addr_reg, 16'h0000);
          end else if (MEM_ACK_IN) begin
            tmp_reg   <= MEM_RDATA_IN;
            state_reg <= S_PUSHL;
          end
        end
        S_PUSHL: begin
          if (!mem_req_reg) begin
            gpr_reg[6] <= word_step(gpr_reg[6], 1'b1);
            mem_issue(1'b1, word_step(gpr_reg[6], 1'b1),
                      gpr_reg[link_sel]);
          end else if (MEM_ACK_IN) begin
            // With PC as link the later PC write wins, SP alone else
            gpr_reg[link_sel] <= gpr_reg[7]; // and
            gpr_reg[7]        <= tmp_reg;
            finish;
          end
        end
        S_POPR: begin
          if (!mem_req_reg) begin
            mem_issue(1'b0, gpr_reg[6], 16'h0000);
          end else if (MEM_ACK_IN) begin
            gpr_reg[6]       <= word_step(gpr_reg[6], 1'b0);
            gpr_reg[dst_sel] <= MEM_RDATA_IN;
            finish;
          end
        end
        S_PUSHPS: begin
          if (!mem_req_reg) begin
            gpr_reg[6] <= word_step(gpr_reg[6], 1'b1);
            mem_issue(1'b1, word_step(gpr_reg[6], 1'b1),
                      psw_reg);
          end else if (MEM_ACK_IN) begin
            state_reg <= S_PUSHPC;
          end
        end
        S_PUSHPC: begin
          if (!mem_req_reg) begin
            gpr_reg[6] <= word_step(gpr_reg[6], 1'b1);
            mem_issue(1'b1, word_step(gpr_reg[6], 1'b1),
                      gpr_reg[7]);
          end else if (MEM_ACK_IN) begin
            state_reg <= S_VECPC;
          end
        end
        S_VECPC: begin
          if (!mem_req_reg) begin
            mem_issue(1'b0, vec_reg, 16'h0000);
          end else if (MEM_ACK_IN) begin
            gpr_reg[7] <= MEM_RDATA_IN;
            state_reg  <= S_VECPS;
          end
        end
        S_VECPS: begin
          if (!mem_req_reg) begin
            mem_issue(1'b0, word_step(vec_reg, 1'b0),
                      16'h0000);
          end else if (MEM_ACK_IN) begin
            psw_reg <= MEM_RDATA_IN;
            finish;
          end
        end
        S_POPPC: begin
          if (!mem_req_reg) begin
            mem_issue(1'b0, gpr_reg[6], 16'h0000);
          end else if (MEM_ACK_IN) begin
            gpr_reg[7] <= MEM_RDATA_IN;
            gpr_reg[6] <= word_step(gpr_reg[6], 1'b0);
            state_reg  <= S_POPPS;
          end
        end
        S_POPPS: begin
          if (!mem_req_reg) begin
            mem_issue(1'b0, gpr_reg[6], 16'h0000);
          end else if (MEM_ACK_IN) begin
            psw_reg    <= MEM_RDATA_IN;
            gpr_reg[6] <= word_step(gpr_reg[6], 1'b0);
            finish;
          end
        end
        default: begin
          state_reg <= S_IDLE;
          busy_reg  <= 1'b0;
        end
      endcase
    end
  end

  // Outputs straight from flops
  assign MEM_REQ_OUT   = mem_req_reg;
  assign MEM_WE_OUT    = mem_we_reg;
  assign MEM_ADDR_OUT  = mem_addr_reg;
  assign MEM_WDATA_OUT = mem_wdata_reg;
  assign BUSY_OUT      = busy_reg;
  assign DONE_OUT      = done_reg;
  assign ILLEGAL_OUT   = illegal_reg;
  assign REG_RDATA_OUT = rdata_reg;
  assign PSW_OUT       = psw_reg;

endmodule

// >>> exec_checker.sv
// Port-level checks for the call, return, loop and trap unit
module exec_checker (
  // Clock and reset
  input wire logic        MCLK_IN,
  input wire logic        RESETN_IN,
  // Status word load
  input wire logic        PSW_WE_IN,
  // Memory handshake
  input wire logic        MEM_ACK_IN,
  input wire logic        MEM_REQ_OUT,
  input wire logic        MEM_WE_OUT,
  input wire logic [15:0] MEM_ADDR_OUT,
  // Status
  input wire logic        BUSY_OUT,
  input wire logic        DONE_OUT,
  input wire logic        ILLEGAL_OUT,
  input wire logic [15:0] PSW_OUT
);
  timeunit 1ns;
  timeprecision 1ns;

  logic        req_d_reg;
  logic        prev_we_reg;
  logic        prev2_we_reg;
  logic        prev_vec_reg;
  logic [15:0] prev_reg;
  logic [15:0] prev2_reg;
  wire         req_rise = MEM_REQ_OUT && !req_d_reg;
  wire         vec_w = (MEM_ADDR_OUT == 16'h0008) ||
                       (MEM_ADDR_OUT == 16'h000c) ||
                       (MEM_ADDR_OUT == 16'h0018) ||
                       (MEM_ADDR_OUT == 16'h001c);

  // History of the last two requests; cleared so a reset mid-trap is clean
  always @(posedge MCLK_IN) begin
    if (!RESETN_IN) begin
      req_d_reg    <= 1'b0;
      prev_vec_reg <= 1'b0;
      prev_we_reg  <= 1'b0;
      prev2_we_reg <= 1'b0;
      prev_reg     <= 16'h0000;
      prev2_reg    <= 16'h0000;
    end else begin
      req_d_reg <= MEM_REQ_OUT;
      if (req_rise) begin
        prev_reg     <= MEM_ADDR_OUT;
        prev2_reg    <= prev_reg;
        prev_we_reg  <= MEM_WE_OUT;
        prev2_we_reg <= prev_we_reg;
        prev_vec_reg <= vec_w && !MEM_WE_OUT;
      end
    end
  end

  default clocking @(posedge MCLK_IN); endclocking
  default disable iff (!RESETN_IN);

  a_req_holds: assert property (MEM_REQ_OUT && !MEM_ACK_IN |=>
    MEM_REQ_OUT && $stable(MEM_ADDR_OUT) && $stable(MEM_WE_OUT))
    else $error("memory request changed before ack");
  a_req_release: assert property (MEM_REQ_OUT && MEM_ACK_IN |=>
    !MEM_REQ_OUT) else $error("memory request held after ack");
  a_done_pulse: assert property (DONE_OUT |=> !DONE_OUT)
    else $error("done longer than one cycle");
  a_done_ends_busy: assert property (DONE_OUT |->
    !BUSY_OUT && $past(BUSY_OUT)) else $error("done without busy");
  a_busy_bounded: assert property ($rose(BUSY_OUT) |->
    ##[1:80] DONE_OUT) else $error("sequence did not finish");
  a_illegal_vector: assert property (ILLEGAL_OUT |-> ##[1:80]
    (MEM_REQ_OUT && !MEM_WE_OUT && MEM_ADDR_OUT == 16'h0008))
    else $error("illegal call did not fetch vector 8");
  a_vector_pair: assert property (req_rise && prev_vec_reg |->
    !MEM_WE_OUT && MEM_ADDR_OUT == prev_reg + 16'h0002)
    else $error("status word not read from vector plus two");
  a_status_first: assert property (req_rise &&
    !MEM_WE_OUT && vec_w |->
    prev_we_reg && prev2_we_reg && prev2_reg == prev_reg + 16'h0002)
    else $error("trap pushes out of order");
  a_status_kept: assert property (!BUSY_OUT &&
    !$past(BUSY_OUT) && !$past(PSW_WE_IN) && $past(RESETN_IN) |->
    $stable(PSW_OUT))
    else $error("status word changed while idle");

  c_illegal: cover property (ILLEGAL_OUT);
  c_write_ack: cover property (MEM_REQ_OUT && MEM_ACK_IN && MEM_WE_OUT);
  c_vector_read: cover property (req_rise && vec_w && !MEM_WE_OUT);
endmodule

bind subroutine_loop_trap_exec exec_checker chk_u (
  .MCLK_IN(MCLK_IN), .RESETN_IN(RESETN_IN), .PSW_WE_IN(PSW_WE_IN),
  .MEM_ACK_IN(MEM_ACK_IN), .MEM_REQ_OUT(MEM_REQ_OUT),
  .MEM_WE_OUT(MEM_WE_OUT), .MEM_ADDR_OUT(MEM_ADDR_OUT),
  .BUSY_OUT(BUSY_OUT), .DONE_OUT(DONE_OUT), .ILLEGAL_OUT(ILLEGAL_OUT),
  .PSW_OUT(PSW_OUT));

// >>> sys_memory.sv
// Word memory holding stack, arguments and trap vectors
module sys_memory (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Request side
  input  wire logic        req,
  input  wire logic        we,
  input  wire logic [15:0] addr,
  input  wire logic [15:0] wdata,
  input  wire logic [1:0]  lag,
  // Answer side
  output logic             ack,
  output logic [15:0]      rdata
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [15:0] words [0:255];
  int          cnt;

  // Answer after lag wait cycles; read data is inverted on every cycle with no request pending and held while waiting
  always @(posedge clk) begin
    if (!rst_n) begin
      ack   <= 1'b0;
      cnt   <= 0;
      rdata <= 16'h5a5a;
    end else if (ack || !req) begin
      ack   <= 1'b0;
      cnt   <= 0;
      rdata <= ~rdata;
    end else if (cnt >= lag) begin
      ack <= 1'b1;
      if (we)
        words[addr[8:1]] <= wdata;
      else
        rdata <= words[addr[8:1]];
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule

// >>> tb_subroutine_loop_trap_exec.sv
// Self-checking bench for the call, return, loop and trap unit
module tb_subroutine_loop_trap_exec;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk = 0, rst_n = 0, start = 0, trq = 0, rwe = 0, pwe = 0;
  logic [15:0] ins = 0, rwd = 0, pwd = 0;
  logic [2:0]  rws = 0, rrs = 0;
  logic [1:0]  tsel = 0, lag = 0;
  wire         ack, req, mwe, busy, done, ill;
  wire  [15:0] rdata, addr, wdata, rrd, psw_o;
  logic [15:0] r [0:7];
  logic [15:0] m [0:255];
  logic [15:0] psw, v, t, d;
  logic        seen_ill;
  logic [2:0]  lk, md, ds;
  int          fails = 0, checked = 0, seed = 62, cyc = 0, k;
  localparam logic [15:0] VECS [0:3] = '{16'h0008, 16'h000c,
                                         16'h0018, 16'h001c};

  always #25 clk = ~clk;

  subroutine_loop_trap_exec dut_u (
    .MCLK_IN(clk), .RESETN_IN(rst_n), .START_IN(start), .INSTR_IN(ins),
    .TRAP_REQ_IN(trq), .TRAP_SEL_IN(tsel), .REG_WE_IN(rwe),
    .REG_WSEL_IN(rws), .REG_WDATA_IN(rwd), .REG_RSEL_IN(rrs),
    .PSW_WE_IN(pwe), .PSW_WDATA_IN(pwd), .MEM_ACK_IN(ack),
    .MEM_RDATA_IN(rdata), .MEM_REQ_OUT(req), .MEM_WE_OUT(mwe),
    .MEM_ADDR_OUT(addr), .MEM_WDATA_OUT(wdata), .BUSY_OUT(busy),
    .DONE_OUT(done), .ILLEGAL_OUT(ill), .REG_RDATA_OUT(rrd),
    .PSW_OUT(psw_o));

  sys_memory mem_u (.clk(clk), .rst_n(rst_n), .req(req), .we(mwe),
    .addr(addr), .wdata(wdata), .lag(lag), .ack(ack), .rdata(rdata));

  task automatic cmp(input string n, input logic [15:0] e, g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic end_of_test();
    if (fails == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Hang guard: far above the longest expected run
  always @(posedge clk) begin
    cyc++;
    if (cyc > 30000) begin
      fails++;
      end_of_test();
    end
  end

  task automatic poke(input logic [15:0] a, x);
    m[a >> 1] = x;
    mem_u.words[a >> 1] = x;
  endtask

  task automatic setr(input logic [2:0] n, input logic [15:0] x);
    @(posedge clk);
    rwe <= 1'b1;
    rws <= n;
    rwd <= x;
    r[n] = x;
    @(posedge clk);
    rwe <= 1'b0;
  endtask

  // Random registers and status; stack kept in the modelled memory
  task automatic load();
    for (int j = 0; j < 8; j++)
      setr(j[2:0], j == 6 ? 16'h0180 : $random(seed) & 16'hfffe);
    psw = $random(seed);
    @(posedge clk);
    pwe <= 1'b1;
    pwd <= psw;
    lag <= $random(seed);
    @(posedge clk);
    pwe <= 1'b0;
  endtask

  // Issue one instruction or trap and wait for its end
  task automatic run(input logic [15:0] x, input logic tr,
                     input logic [1:0] s);
    int n;
    n = 0;
    seen_ill = 0;
    @(posedge clk);
    start <= !tr;
    trq   <= tr;
    ins   <= x;
    tsel  <= s;
    @(posedge clk);
    start <= 1'b0;
    trq   <= 1'b0;
    while (done !== 1'b1 && n < 200) begin
      @(negedge clk);
      if (ill === 1'b1)
        seen_ill = 1;
      n++;
    end
    // A sequence that never ends counts against the run here
    cmp("done", 16'h0001, {15'h0000, done});
  endtask

  task automatic chk();
    for (int j = 0; j < 8; j++) begin
      @(posedge clk);
      rrs <= j[2:0];
      @(posedge clk);
      @(negedge clk);
      cmp($sformatf("r%0d", j), r[j], rrd);
    end
    cmp("psw", psw, psw_o);
    cmp("stack0", m[r[6] >> 1], mem_u.words[r[6] >> 1]);
    cmp("stack1", m[(r[6] >> 1) + 1], mem_u.words[(r[6] >> 1) + 1]);
  endtask

  // Trap entry expectation: status pushed first, then PC
  task automatic trap_exp(input logic [15:0] a);
    r[6] -= 2;
    m[r[6] >> 1] = psw;
    r[6] -= 2;
    m[r[6] >> 1] = r[7];
    r[7] = m[a >> 1];
    psw = m[(a >> 1) + 1];
  endtask

  initial begin
    for (k = 0; k < 256; k++)
      poke(16'(2 * k), $random(seed) & 16'hfffe);
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    // Loop: count of one falls through, widest offset, random counts
    for (k = 0; k < 6; k++) begin
      load();
      v = k == 0 ? 16'h0001 : $random(seed);
      t = k == 1 ? 16'h003f : $random(seed);
      setr(k[2:0], v);
      run({7'h3f, k[2:0], t[5:0]}, 1'b0, 2'h0);
      r[k] = v - 16'h0001;
      if (r[k] != 16'h0000)
        r[7] = r[7] - {9'h000, t[5:0], 1'b0};
      chk();
    end
    // Call in every memory mode; R5 as its own target, PC as link last
    for (k = 0; k < 9; k++) begin
      load();
      lk = k == 8 ? 3'h7 : 3'h5;
      md = (k < 2 || k == 8) ? 3'h1 : k[2:0];
      ds = k == 0 ? 3'h5 : 3'h2;
      // Pointers kept inside the modelled memory, clear of the stack
      setr(3'h2, 16'h0100 | 16'($random(seed) & 16'h003e));
      setr(3'h7, 16'h0040 | 16'($random(seed) & 16'h003e));
      run({7'h04, lk, md, ds}, 1'b0, 2'h0);
      cmp("illegal", 16'h0000, {15'h0000, seen_ill});
      // Destination from the old registers, before the link changes
      d = r[ds];
      case (md)
        3'h1: t = d;
        3'h2: begin
          t = d;
          r[ds] = d + 2;
        end
        3'h3: begin
          t = m[d[8:1]];
          r[ds] = d + 2;
        end
        3'h4: begin
          r[ds] = d - 2;
          t = r[ds];
        end
        3'h5: begin
          r[ds] = d - 2;
          t = m[r[ds][8:1]];
        end
        default: begin
          v = d + m[r[7][8:1]];
          r[7] += 2;
          t = md == 3'h6 ? v : m[v[8:1]];
        end
      endcase
      r[6] -= 2;
      m[r[6] >> 1] = r[lk];
      r[lk] = r[7];
      r[7] = t;
      chk();
    end
    // Coroutine swap through the stack top
    load();
    t = $random(seed) & 16'hfffe;
    poke(r[6], t);
    run({7'h04, 3'h7, 3'h3, 3'h6}, 1'b0, 2'h0);
    m[r[6] >> 1] = r[7];
    r[7] = t;
    chk();
    // Register-mode call becomes an illegal trap
    load();
    run({7'h04, 3'h5, 3'h0, 3'h1}, 1'b0, 2'h0);
    cmp("illegal", 16'h0001, {15'h0000, seen_ill});
    trap_exp(16'h0008);
    chk();
    // Every trap source, each undone by one of the two returns
    for (k = 0; k < 8; k++) begin
      load();
      run(16'h0000, 1'b1, k[1:0]);
      trap_exp(VECS[k % 4]);
      chk();
      run(k[2] ? 16'h0006 : 16'h0002, 1'b0, 2'h0);
      r[7] = m[r[6] >> 1];
      psw = m[(r[6] >> 1) + 1];
      r[6] += 4;
      chk();
    end
    // Return through a linkage register
    for (k = 0; k < 3; k++) begin
      load();
      run(16'h0085, 1'b0, 2'h0);
      r[7] = r[5];
      r[5] = m[r[6] >> 1];
      r[6] += 2;
      chk();
    end
    end_of_test();
  end
endmodule
